// ---- rtl/dpll_regs_pkg.sv ----
// shared constants and types for the holdover control register bank
package dpll_regs_pkg;

  // register byte addresses
  localparam logic [7:0] SHORT_HIST_ADDR = 8'h28;
  localparam logic [7:0] USER_HIST_ADDR = 8'h2c;
  localparam logic [7:0] RAMP_ADDR = 8'h30;
  localparam logic [7:0] PRIO_ADDR = 8'h31;
  localparam logic [7:0] PRIO_LAST_ADDR = 8'h36;
  localparam logic [7:0] PLL_STATE_ADDR = 8'h37;
  localparam logic [7:0] FLUSH_ADDR = 8'h38;
  localparam logic [7:0] AUX_CTRL_ADDR = 8'h39;
  localparam logic [7:0] AUX_BW_ADDR = 8'h3a;
  localparam logic [7:0] AUX_AUTO_ADDR = 8'h3b;
  localparam logic [7:0] AUX_MANUAL_ADDR = 8'h3c;

  // reset values
  localparam logic [31:0] USER_HIST_RESET = 32'h0000_0000;
  localparam logic [6:0] RAMP_RESET = 7'h26;
  localparam logic [47:0] PRIO_RESET = 48'h0000_0000_0000;
  localparam logic [5:0] AUX_CTRL_RESET = 6'h00;
  localparam logic [4:0] AUX_BW_RESET = 5'h00;
  localparam logic [3:0] AUX_MANUAL_RESET = 4'h0;

  // field positions and limits
  localparam int AUX_PHASE_BIT = 0;
  localparam int AUX_USER_HIST_BIT = 2;
  localparam int AUX_REVERT_BIT = 3;
  localparam int AUX_AUTO_BIT = 4;
  localparam int AUX_FOLLOW_BIT = 5;
  localparam logic [5:0] AUX_CTRL_MASK = 6'h3d;
  localparam int FLUSH_SCOPE_BIT = 0;
  localparam logic [2:0] LONG_BW_MAX = 3'h5;
  localparam logic [4:0] AUX_BW_MAX = 5'h0a;
  localparam logic [3:0] REF_LAST = 4'hc;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } reg_req_type;

  // status flags from the system generator core, msb first as in the byte
  typedef struct packed {
    logic long_history_available;
    logic long_history_complete;
    logic outside_pullin_range;
    logic lock_lost;
    logic signal_lost;
    logic sync;
  } pll_flags_type;

  typedef struct packed {
    logic [2:0] long_bw;
    logic [1:0] short_bw;
    logic [1:0] ramp;
  } holdover_cfg_type;

  typedef enum logic [1:0] {
    AUX_FREERUN,
    AUX_LOCKED,
    AUX_HOLDOVER
  } aux_state_type;

endpackage : dpll_regs_pkg

// ---- rtl/ref_auto_select.sv ----
// automatic reference selector over a packed priority table
`timescale 1ns/1ps
`default_nettype none
module ref_auto_select #(
  parameter int NUM_REFS = 12,
  parameter int PRIO_W = 4,
  parameter int SEL_W = 4
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // selection inputs
  input wire logic [NUM_REFS*PRIO_W-1:0] prio_table_i,
  input wire logic [NUM_REFS-1:0] qualified_i,
  input wire logic revertive_i,
  // chosen reference, zero when none
  output logic [SEL_W-1:0] sel_o
);

  logic [SEL_W-1:0] sel;
  logic [SEL_W-1:0] next_sel;
  logic [SEL_W-1:0] best_ref;
  logic [PRIO_W-1:0] best_prio;
  logic cur_ok;

  always_comb begin
    best_ref = '0;
    best_prio = '1;
    cur_ok = 1'b0;
    for (int i = 0; i < NUM_REFS; i++) begin
      if (qualified_i[i] && prio_table_i[i*PRIO_W +: PRIO_W] != '0 &&
          (best_ref == '0 || prio_table_i[i*PRIO_W +: PRIO_W] < best_prio))
      begin
        best_ref = SEL_W'(i + 1);
        best_prio = prio_table_i[i*PRIO_W +: PRIO_W];
      end
      if (sel == SEL_W'(i + 1) && qualified_i[i] &&
          prio_table_i[i*PRIO_W +: PRIO_W] != '0) begin
        cur_ok = 1'b1;
      end
    end
    // non-revertive keeps a still usable reference
    next_sel = (!revertive_i && cur_ok) ? sel : best_ref;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel <= '0;
    end else if (ce_i) begin
      sel <= next_sel;
    end
  end

  assign sel_o = sel;

endmodule : ref_auto_select
`default_nettype wire

// ---- rtl/dpll_holdover_control_regs.sv ----
// holdover, priority and auxiliary generator control register bank
// Operation
// - short-term history readable as four bytes, least significant first
// - writable 32-bit user history, four bytes, resets to zero
// - ramp register: long bandwidth 6:4, short bandwidth 3:2, ramp 1:0
// - twelve 4-bit priorities, odd reference low nibble, even high nibble
// - priority zero excludes a reference; lower nonzero value wins
// - status bits 0..3: sync, signal lost, lock lost, outside pull-in
// - status bit 6 history complete, bit 7 history available, 5:4 zero
// - any write to flush address issues a one-shot flush command
// - flush bit 0 zero clears current history, one clears all
// - auxiliary control bit 0 selects phase alignment on lock
// - auxiliary control bit 2 selects user history instead of device
// - bit 4 auto selection, bit 3 revertive; register resets zero
// - bit 5 in manual mode: one follows reference outside pull-in
// - auxiliary bandwidth code 0..10 used; reserved codes ignored
// - auto-selected auxiliary reference readable as 0..12
// - manual code zero free-runs, 1..12 lock to that reference
// - manual codes 13..15 force holdover; field resets zero
`timescale 1ns/1ps
`default_nettype none
module dpll_holdover_control_regs
  import dpll_regs_pkg::*;
#(
  parameter int NUM_REFS = 12
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // host register port
  input wire reg_req_type req_i,
  output logic [7:0] rdata_o,
  // system generator core
  input wire logic [31:0] sys_short_hist_i,
  input wire pll_flags_type sys_flags_i,
  input wire logic [NUM_REFS-1:0] ref_qualified_i,
  output logic [31:0] sys_user_hist_o,
  output holdover_cfg_type sys_holdover_cfg_o,
  output logic [NUM_REFS*4-1:0] sys_prio_table_o,
  output logic [3:0] sys_auto_ref_o,
  output logic flush_pulse_o,
  output logic flush_all_o,
  // auxiliary generator core
  input wire logic [NUM_REFS*4-1:0] aux_prio_table_i,
  input wire logic aux_ref_oop_i,
  output logic aux_phase_align_o,
  output logic aux_use_user_hist_o,
  output logic [4:0] aux_bw_code_o,
  output aux_state_type aux_state_o,
  output logic [3:0] aux_active_ref_o
);

  logic [31:0] user_hist, next_user_hist;
  logic [6:0] hold_cfg, next_hold_cfg;
  logic [2:0] long_bw_eff, next_long_bw_eff;
  logic [NUM_REFS*4-1:0] prio, next_prio;
  logic [5:0] aux_ctrl, next_aux_ctrl;
  logic [4:0] aux_bw, next_aux_bw;
  logic [4:0] aux_bw_eff, next_aux_bw_eff;
  logic [3:0] aux_manual, next_aux_manual;
  logic [31:0] snap, next_snap;
  logic [7:0] rdata, next_rdata;
  logic flush_pulse, next_flush_pulse;
  logic flush_all, next_flush_all;
  logic [7:0] prio_byte;
  logic [3:0] aux_auto_ref;
  aux_state_type aux_state, next_aux_state;
  logic [3:0] aux_ref, next_aux_ref;

  assign prio_byte = req_i.addr - PRIO_ADDR;

  // system table selector
  ref_auto_select #(.NUM_REFS(NUM_REFS), .PRIO_W(4), .SEL_W(4)) u_sys_sel (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .prio_table_i(prio),
    .qualified_i(ref_qualified_i),
    .revertive_i(1'b1),
    .sel_o(sys_auto_ref_o)
  );

  // auxiliary table selector
  ref_auto_select #(.NUM_REFS(NUM_REFS), .PRIO_W(4), .SEL_W(4)) u_aux_sel (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .prio_table_i(aux_prio_table_i),
    .qualified_i(ref_qualified_i),
    .revertive_i(aux_ctrl[AUX_REVERT_BIT]),
    .sel_o(aux_auto_ref)
  );

  // register file: writes and read mux
  always_comb begin
    next_user_hist = user_hist;
    next_hold_cfg = hold_cfg;
    next_long_bw_eff = long_bw_eff;
    next_prio = prio;
    next_aux_ctrl = aux_ctrl;
    next_aux_bw = aux_bw;
    next_aux_bw_eff = aux_bw_eff;
    next_aux_manual = aux_manual;
    next_snap = snap;
    next_rdata = rdata;
    next_flush_pulse = 1'b0;
    next_flush_all = flush_all;
    if (req_i.wr) begin
      if (req_i.addr[7:2] == USER_HIST_ADDR[7:2]) begin
        next_user_hist[{req_i.addr[1:0], 3'b000} +: 8] = req_i.wdata;
      end
      if (req_i.addr == RAMP_ADDR) begin
        next_hold_cfg = req_i.wdata[6:0];
        if (req_i.wdata[6:4] <= LONG_BW_MAX) begin
          next_long_bw_eff = req_i.wdata[6:4];
        end
      end
      if (req_i.addr >= PRIO_ADDR && req_i.addr <= PRIO_LAST_ADDR) begin
        next_prio[{prio_byte[2:0], 3'b000} +: 8] = req_i.wdata;
      end
      if (req_i.addr == FLUSH_ADDR) begin
        next_flush_pulse = 1'b1;
        next_flush_all = req_i.wdata[FLUSH_SCOPE_BIT];
      end
      if (req_i.addr == AUX_CTRL_ADDR) begin
        next_aux_ctrl = req_i.wdata[5:0] & AUX_CTRL_MASK;
      end
      if (req_i.addr == AUX_BW_ADDR) begin
        next_aux_bw = req_i.wdata[4:0];
        if (req_i.wdata[4:0] <= AUX_BW_MAX) begin
          next_aux_bw_eff = req_i.wdata[4:0];
        end
      end
      if (req_i.addr == AUX_MANUAL_ADDR) begin
        next_aux_manual = req_i.wdata[3:0];
      end
    end
    if (req_i.rd) begin
      next_rdata = 8'h00;
      if (req_i.addr[7:2] == SHORT_HIST_ADDR[7:2]) begin
        if (req_i.addr[1:0] == 2'h0) begin
          next_snap = sys_short_hist_i;
          next_rdata = sys_short_hist_i[7:0];
        end else begin
          next_rdata = snap[{req_i.addr[1:0], 3'b000} +: 8];
        end
      end
      if (req_i.addr[7:2] == USER_HIST_ADDR[7:2]) begin
        next_rdata = user_hist[{req_i.addr[1:0], 3'b000} +: 8];
      end
      if (req_i.addr >= PRIO_ADDR && req_i.addr <= PRIO_LAST_ADDR) begin
        next_rdata = prio[{prio_byte[2:0], 3'b000} +: 8];
      end
      case (req_i.addr)
        RAMP_ADDR: next_rdata = {1'b0, hold_cfg};
        PLL_STATE_ADDR: next_rdata = {sys_flags_i[5:4], 2'b00,
                                      sys_flags_i[3:0]};
        AUX_CTRL_ADDR: next_rdata = {2'b00, aux_ctrl};
        AUX_BW_ADDR: next_rdata = {3'b000, aux_bw};
        AUX_AUTO_ADDR: next_rdata = {4'h0, aux_auto_ref};
        AUX_MANUAL_ADDR: next_rdata = {4'h0, aux_manual};
        default: next_rdata = next_rdata;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      user_hist <= USER_HIST_RESET;
      hold_cfg <= RAMP_RESET;
      long_bw_eff <= RAMP_RESET[6:4];
      prio <= PRIO_RESET[NUM_REFS*4-1:0];
      aux_ctrl <= AUX_CTRL_RESET;
      aux_bw <= AUX_BW_RESET;
      aux_bw_eff <= AUX_BW_RESET;
      aux_manual <= AUX_MANUAL_RESET;
      snap <= 32'h0000_0000;
      rdata <= 8'h00;
      flush_pulse <= 1'b0;
      flush_all <= 1'b0;
    end else if (ce_i) begin
      user_hist <= next_user_hist;
      hold_cfg <= next_hold_cfg;
      long_bw_eff <= next_long_bw_eff;
      prio <= next_prio;
      aux_ctrl <= next_aux_ctrl;
      aux_bw <= next_aux_bw;
      aux_bw_eff <= next_aux_bw_eff;
      aux_manual <= next_aux_manual;
      snap <= next_snap;
      rdata <= next_rdata;
      flush_pulse <= next_flush_pulse;
      flush_all <= next_flush_all;
    end
  end

  // auxiliary generator operating state
  always_comb begin
    next_aux_state = AUX_FREERUN;
    next_aux_ref = 4'h0;
    if (aux_ctrl[AUX_AUTO_BIT]) begin
      next_aux_ref = aux_auto_ref;
      next_aux_state = (aux_auto_ref == 4'h0) ? AUX_HOLDOVER : AUX_LOCKED;
    end else if (aux_manual == 4'h0) begin
      next_aux_state = AUX_FREERUN;
    end else if (aux_manual <= REF_LAST) begin
      if (aux_ref_oop_i && !aux_ctrl[AUX_FOLLOW_BIT]) begin
        next_aux_state = AUX_HOLDOVER;
      end else begin
        next_aux_state = AUX_LOCKED;
        next_aux_ref = aux_manual;
      end
    end else begin
      next_aux_state = AUX_HOLDOVER;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aux_state <= AUX_FREERUN;
      aux_ref <= 4'h0;
    end else if (ce_i) begin
      aux_state <= next_aux_state;
      aux_ref <= next_aux_ref;
    end
  end

  assign rdata_o = rdata;
  assign sys_user_hist_o = user_hist;
  assign sys_holdover_cfg_o = {long_bw_eff, hold_cfg[3:0]};
  assign sys_prio_table_o = prio;
  assign flush_pulse_o = flush_pulse;
  assign flush_all_o = flush_all;
  assign aux_phase_align_o = aux_ctrl[AUX_PHASE_BIT];
  assign aux_use_user_hist_o = aux_ctrl[AUX_USER_HIST_BIT];
  assign aux_bw_code_o = aux_bw_eff;
  assign aux_state_o = aux_state;
  assign aux_active_ref_o = aux_ref;

  AST_SHORT_HIST_LSB: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.rd && req_i.addr == SHORT_HIST_ADDR)
      |=> rdata_o == $past(sys_short_hist_i[7:0]))
    else $error("short history low byte wrong");

  AST_HIST_COHERENT: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.rd && req_i.addr == SHORT_HIST_ADDR)
      ##1 !(ce_i && req_i.rd && req_i.addr == SHORT_HIST_ADDR)
      ##1 (ce_i && req_i.rd && !(req_i.wr) &&
           req_i.addr == {SHORT_HIST_ADDR[7:2], 2'h3})
      |=> rdata_o == $past(sys_short_hist_i[31:24], 3))
    else $error("history bytes not coherent");

  AST_USER_HIST_TOP: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.wr && req_i.addr == {USER_HIST_ADDR[7:2], 2'h3})
      |=> sys_user_hist_o[31:24] == $past(req_i.wdata))
    else $error("user history top byte not stored");

  AST_LONG_BW_RESERVED: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.wr && req_i.addr == RAMP_ADDR &&
     req_i.wdata[6:4] > LONG_BW_MAX)
      |=> $stable(sys_holdover_cfg_o.long_bw))
    else $error("reserved long bandwidth applied");

  AST_PRIO_NIBBLES: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.wr && req_i.addr == PRIO_LAST_ADDR)
      |=> sys_prio_table_o[47:44] == $past(req_i.wdata[7:4]) &&
          sys_prio_table_o[43:40] == $past(req_i.wdata[3:0]))
    else $error("priority nibbles misplaced");

  AST_STATUS_BYTE: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.rd && req_i.addr == PLL_STATE_ADDR)
      |=> rdata_o[5:4] == 2'b00 &&
          rdata_o[7] == $past(sys_flags_i.long_history_available) &&
          rdata_o[0] == $past(sys_flags_i.sync))
    else $error("status byte wrong");

  AST_FLUSH_ONE_SHOT: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.wr && req_i.addr == FLUSH_ADDR)
      |=> flush_pulse_o && flush_all_o == $past(req_i.wdata[0]))
    else $error("flush command not issued");

  AST_BW_RESERVED: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && req_i.wr && req_i.addr == AUX_BW_ADDR &&
     req_i.wdata[4:0] > AUX_BW_MAX)
      |=> $stable(aux_bw_code_o))
    else $error("reserved bandwidth applied");

  AST_MANUAL_HOLDOVER: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && !aux_ctrl[AUX_AUTO_BIT] && aux_manual > REF_LAST)
      |=> aux_state_o == AUX_HOLDOVER && aux_active_ref_o == 4'h0)
    else $error("manual holdover not forced");

  AST_MANUAL_FREERUN: assert property (@(posedge sys_clk_i)
    disable iff (!rst_n_i)
    (ce_i && !aux_ctrl[AUX_AUTO_BIT] && aux_manual == 4'h0)
      |=> aux_state_o == AUX_FREERUN)
    else $error("manual free-run not taken");

endmodule : dpll_holdover_control_regs
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking testbench for the holdover control register bank
`timescale 1ns/1ps
`default_nettype none
module tb
  import dpll_regs_pkg::*;
;
  logic sys_clk_i;
  logic rst_n_i;
  logic ce_i;
  reg_req_type req_i;
  logic [7:0] rdata_o;
  logic [31:0] sys_short_hist_i;
  pll_flags_type sys_flags_i;
  logic [11:0] ref_qualified_i;
  logic [31:0] sys_user_hist_o;
  holdover_cfg_type sys_holdover_cfg_o;
  logic [47:0] sys_prio_table_o;
  logic [3:0] sys_auto_ref_o;
  logic flush_pulse_o;
  logic flush_all_o;
  logic [47:0] aux_prio_table_i;
  logic aux_ref_oop_i;
  logic aux_phase_align_o;
  logic aux_use_user_hist_o;
  logic [4:0] aux_bw_code_o;
  aux_state_type aux_state_o;
  logic [3:0] aux_active_ref_o;
  aux_state_type exp_state;
  logic [3:0] exp_ref;
  int fail_count;
  int comparisons;

  dpll_holdover_control_regs #(.NUM_REFS(12)) dut (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .req_i(req_i),
    .rdata_o(rdata_o),
    .sys_short_hist_i(sys_short_hist_i),
    .sys_flags_i(sys_flags_i),
    .ref_qualified_i(ref_qualified_i),
    .sys_user_hist_o(sys_user_hist_o),
    .sys_holdover_cfg_o(sys_holdover_cfg_o),
    .sys_prio_table_o(sys_prio_table_o),
    .sys_auto_ref_o(sys_auto_ref_o),
    .flush_pulse_o(flush_pulse_o),
    .flush_all_o(flush_all_o),
    .aux_prio_table_i(aux_prio_table_i),
    .aux_ref_oop_i(aux_ref_oop_i),
    .aux_phase_align_o(aux_phase_align_o),
    .aux_use_user_hist_o(aux_use_user_hist_o),
    .aux_bw_code_o(aux_bw_code_o),
    .aux_state_o(aux_state_o),
    .aux_active_ref_o(aux_active_ref_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    req_i <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge sys_clk_i);
    req_i <= '{addr: a, wr: 1'b0, rd: 1'b0, wdata: d};
    #1;
  endtask : wr

  // read one byte and compare it 1 ns after the edge that samples the read
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    req_i <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge sys_clk_i);
    req_i.rd <= 1'b0;
    #1;
    check(48'(rdata_o), 48'(exp));
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : idle

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fail_count++;
    wrap_up();
  end

  initial begin
    fail_count = 0;
    comparisons = 0;
    rst_n_i = 1'b0;
    ce_i = 1'b1;
    req_i = '0;
    sys_short_hist_i = 32'h0000_0000;
    sys_flags_i = '0;
    ref_qualified_i = 12'hfff;
    aux_prio_table_i = 48'h0;
    aux_ref_oop_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    check(48'(sys_holdover_cfg_o), 48'h26);
    check(48'(aux_state_o), 48'(AUX_FREERUN));
    check(48'(sys_user_hist_o), 48'h0);
    for (int i = 0; i < 4; i++) rd(8'(USER_HIST_ADDR + i), 8'h00);
    for (int i = 0; i < 6; i++) rd(8'(PRIO_ADDR + i), 8'h00);
    rd(RAMP_ADDR, 8'h26);
    rd(AUX_CTRL_ADDR, 8'h00);
    rd(AUX_BW_ADDR, 8'h00);
    rd(AUX_MANUAL_ADDR, 8'h00);
    // history bytes stay coherent while the live value moves
    @(posedge sys_clk_i);
    sys_short_hist_i <= 32'h89ab_cdef;
    rd(SHORT_HIST_ADDR, 8'hef);
    @(posedge sys_clk_i);
    sys_short_hist_i <= 32'h1234_5678;
    rd(8'h29, 8'hcd);
    rd(8'h2a, 8'hab);
    rd(8'h2b, 8'h89);
    rd(SHORT_HIST_ADDR, 8'h78);
    wr(SHORT_HIST_ADDR, 8'h00);
    // the live value moves right after the low byte is taken
    fork
      rd(SHORT_HIST_ADDR, 8'h78);
      begin
        repeat (2) @(posedge sys_clk_i);
        sys_short_hist_i <= 32'hfedc_ba98;
      end
    join
    rd(8'h2b, 8'h12);
    for (int i = 0; i < 4; i++) wr(8'(USER_HIST_ADDR + i), 8'(17 * (i + 1)));
    check(48'(sys_user_hist_o), 48'h4433_2211);
    for (int i = 0; i < 4; i++) begin
      rd(8'(USER_HIST_ADDR + i), 8'(17 * (i + 1)));
    end
    wr(RAMP_ADDR, 8'h5b);
    check(48'(sys_holdover_cfg_o), 48'h5b);
    wr(RAMP_ADDR, 8'hf0);
    rd(RAMP_ADDR, 8'h70);
    check(48'(sys_holdover_cfg_o), 48'h50);
    // system priority table and automatic choice
    wr(PRIO_ADDR, 8'h12);
    wr(PRIO_LAST_ADDR, 8'hc3);
    check(sys_prio_table_o, 48'hc300_0000_0012);
    rd(PRIO_LAST_ADDR, 8'hc3);
    idle(2);
    check(48'(sys_auto_ref_o), 48'h2);
    @(posedge sys_clk_i);
    ref_qualified_i <= 12'hffd;
    idle(3);
    check(48'(sys_auto_ref_o), 48'h1);
    wr(PRIO_ADDR, 8'h10);
    idle(2);
    check(48'(sys_auto_ref_o), 48'hb);
    // status byte
    @(posedge sys_clk_i);
    sys_flags_i <= 6'b101010;
    rd(PLL_STATE_ADDR, 8'h8a);
    @(posedge sys_clk_i);
    sys_flags_i <= 6'b010101;
    rd(PLL_STATE_ADDR, 8'h45);
    wr(PLL_STATE_ADDR, 8'hff);
    rd(PLL_STATE_ADDR, 8'h45);
    rd(8'h00, 8'h00);
    rd(8'h40, 8'h00);
    // flush command, both scopes
    for (int i = 0; i < 2; i++) begin
      wr(FLUSH_ADDR, 8'hfe | 8'(i));
      check(48'(flush_pulse_o), 48'h1);
      check(48'(flush_all_o), 48'(i));
      idle(1);
      check(48'(flush_pulse_o), 48'h0);
    end
    rd(FLUSH_ADDR, 8'h00);
    // auxiliary control bits
    wr(AUX_CTRL_ADDR, 8'hc5);
    check(48'(aux_phase_align_o), 48'h1);
    check(48'(aux_use_user_hist_o), 48'h1);
    rd(AUX_CTRL_ADDR, 8'h05);
    wr(AUX_CTRL_ADDR, 8'h02);
    check(48'(aux_phase_align_o), 48'h0);
    check(48'(aux_use_user_hist_o), 48'h0);
    rd(AUX_CTRL_ADDR, 8'h00);
    for (int i = 0; i < 11; i++) begin
      wr(AUX_BW_ADDR, 8'(i));
      check(48'(aux_bw_code_o), 48'(i));
    end
    wr(AUX_BW_ADDR, 8'h0b);
    check(48'(aux_bw_code_o), 48'h0a);
    rd(AUX_BW_ADDR, 8'h0b);
    // a frozen clock enable takes no write
    @(posedge sys_clk_i);
    ce_i <= 1'b0;
    wr(AUX_BW_ADDR, 8'h03);
    check(48'(aux_bw_code_o), 48'h0a);
    @(posedge sys_clk_i);
    ce_i <= 1'b1;
    wr(AUX_BW_ADDR, 8'h03);
    check(48'(aux_bw_code_o), 48'h03);
    // manual selection over every code
    for (int i = 0; i < 16; i++) begin
      wr(AUX_MANUAL_ADDR, 8'(i));
      idle(1);
      exp_state = (i == 0) ? AUX_FREERUN :
        (i <= 12) ? AUX_LOCKED : AUX_HOLDOVER;
      check(48'(aux_state_o), 48'(exp_state));
      exp_ref = (i >= 1 && i <= 12) ? 4'(i) : 4'h0;
      check(48'(aux_active_ref_o), 48'(exp_ref));
    end
    wr(AUX_MANUAL_ADDR, 8'h03);
    @(posedge sys_clk_i);
    aux_ref_oop_i <= 1'b1;
    idle(3);
    check(48'(aux_state_o), 48'(AUX_HOLDOVER));
    check(48'(aux_active_ref_o), 48'h0);
    wr(AUX_CTRL_ADDR, 8'h20);
    idle(1);
    check(48'(aux_state_o), 48'(AUX_LOCKED));
    check(48'(aux_active_ref_o), 48'h3);
    // automatic selection, non-revertive then revertive
    @(posedge sys_clk_i);
    aux_ref_oop_i <= 1'b0;
    aux_prio_table_i <= 48'h1000_0003_0000;
    ref_qualified_i <= 12'hfff;
    wr(AUX_CTRL_ADDR, 8'h10);
    idle(4);
    rd(AUX_AUTO_ADDR, 8'h0c);
    check(48'(aux_active_ref_o), 48'hc);
    @(posedge sys_clk_i);
    ref_qualified_i <= 12'h7ff;
    idle(4);
    rd(AUX_AUTO_ADDR, 8'h05);
    @(posedge sys_clk_i);
    ref_qualified_i <= 12'hfff;
    idle(4);
    check(48'(aux_active_ref_o), 48'h5);
    wr(AUX_CTRL_ADDR, 8'h18);
    idle(4);
    check(48'(aux_active_ref_o), 48'hc);
    check(48'(aux_state_o), 48'(AUX_LOCKED));
    wrap_up();
  end
endmodule : tb
`default_nettype wire
